/* File: byte_slot.sv */
// Purpose: Picks the byte for one output slot of a trimmed data word
// Assumes: Slot index below keep means the byte is stored
// Notes:   Slot 0 is the first byte in transmit order
`default_nettype none

module byte_slot #(
    parameter int SLOT = 0                        // Output slot index
) (
    input  wire logic [31:0] i_word,              // Written data word
    input  wire logic        i_endian,            // High byte first when set
    input  wire logic [1:0]  i_first,             // Leading bytes dropped
    input  wire logic [2:0]  i_keep,              // Bytes kept
    output var  logic [7:0]  o_byte               // Byte for this slot
);

    localparam logic [2:0] SLOT_IDX = 3'(SLOT);   // Slot at counter width

    logic [2:0] src;                              // Source byte in send order
    logic [1:0] lane;                             // Physical byte lane

    // ****************************************
    // Lane select
    // ****************************************
    always_comb begin
        src  = {1'b0, i_first} + SLOT_IDX;
        // Big endian sends the top lane first
        lane = i_endian ? 2'(3'h3 - src) : src[1:0];
        // Unused slots read zero so the packed word stays clean
        o_byte = (SLOT_IDX < i_keep) ? i_word[{lane, 3'h0} +: 8] : 8'h00;
    end

endmodule

`default_nettype wire

/* File: host_model.sv */
// Purpose: Host processor model driving the register port of the queue block
// Assumes: One access at a time, signals change just after a rising edge
// Notes:   Released write data shows the inverse of its last value
`default_nettype none

module host_model (
    input  wire logic        i_clock,   // Bench clock
    output var  logic [11:0] o_addr,    // Register byte address
    output var  logic        o_wr_en,   // Write strobe
    output var  logic        o_rd_en,   // Read strobe
    output var  logic [31:0] o_wdata,   // Write data
    input  wire logic [31:0] i_rdata,   // Read data
    input  wire logic        i_rvalid   // Read data strobe
);
    timeunit 1ns;
    timeprecision 1ns;

    // ****************************************
    // Bus cycles
    // ****************************************
    // Idle bus at time zero
    initial begin
        o_addr  = 12'h000;
        o_wr_en = 1'b0;
        o_rd_en = 1'b0;
        o_wdata = 32'h0000_0000;
    end

    // One write, held until the sampling edge, then released
    task automatic wr(input logic [11:0] addr, input logic [31:0] data);
        @(posedge i_clock);
        o_addr  <= addr;
        o_wdata <= data;
        o_wr_en <= 1'b1;
        @(posedge i_clock);
        o_wr_en <= 1'b0;
        o_wdata <= ~data;   // Stale data must not look valid
    endtask

    // One read; answer stands for one cycle after the taking edge,
    // so it is picked up mid-cycle before the strobe drops again
    task automatic rd(input logic [11:0] addr, output logic [31:0] data,
                      output logic ok);
        @(posedge i_clock);
        o_addr  <= addr;
        o_rd_en <= 1'b1;
        @(posedge i_clock);
        o_rd_en <= 1'b0;
        @(negedge i_clock);
        data = i_rdata;
        ok   = i_rvalid;
    endtask

    // ****************************************
    // Packet setup sequence
    // ****************************************
    // Control word and size go first, then the setup word
    task automatic setup_pkt(input logic [15:0] size, input logic endian,
                             input logic [1:0] start, input logic [1:0] endm,
                             input logic [13:0] writes);
        wr(12'h000, 32'h0000_0000);
        wr(12'h004, {16'h0000, size});
        // Counter is loaded with the write count minus one
        wr(12'h008, {7'h00, endian, 4'h0, start, endm, 2'h0, writes - 14'h0001});
    endtask

endmodule

`default_nettype wire

/* File: tx_queue_pkg.sv */
// Purpose: Shared constants and state type for the transmit write setup block
// Assumes: 32-bit host data path, word-aligned register offsets
// Notes:   Offsets are byte addresses on the host register port
`default_nettype none

package tx_queue_pkg;

    // ****************************************
    // Widths
    // ****************************************
    localparam int ADDR_W  = 12;         // Host address width
    localparam int DATA_W  = 32;         // Host data width
    localparam int SIZE_W  = 16;         // Packet byte size width
    localparam int COUNT_W = 14;         // Write counter width
    localparam int MASK_W  = 2;          // Start and end mask width
    localparam int LANES   = 4;          // Bytes per data word

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [ADDR_W-1:0] OFF_PACKET_BYTE_SIZE = 12'h004;
    localparam logic [ADDR_W-1:0] OFF_TX_WRITE_SETUP   = 12'h008;
    localparam logic [ADDR_W-1:0] OFF_QUEUE_DATA       = 12'h00C;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int SIZE_LSB   = 0;       // Packet byte size
    localparam int ENDIAN_BIT = 24;      // Byte order select
    localparam int START_LSB  = 18;      // Start mask
    localparam int END_LSB    = 16;      // End mask
    localparam int COUNT_LSB  = 0;       // Write counter

    // ****************************************
    // Reset values and fixed figures
    // ****************************************
    localparam logic [SIZE_W-1:0]  SIZE_RESET  = 16'h0000;
    localparam logic [COUNT_W-1:0] COUNT_RESET = 14'h0000;
    localparam logic [MASK_W-1:0]  MASK_RESET  = 2'h0;
    localparam logic [DATA_W-1:0]  WORD_ZERO   = 32'h0000_0000;
    localparam logic [2:0]         WORD_BYTES  = 3'h4;

    // Block state except the reset synchroniser, registered in one place
    typedef struct packed {
        logic [SIZE_W-1:0]  psz;        // Remaining packet byte size
        logic               endian;     // High byte first when set
        logic [MASK_W-1:0]  start_off;  // Leading bytes to drop
        logic [MASK_W-1:0]  end_off;    // Trailing bytes to drop
        logic [COUNT_W-1:0] count;      // Writes left before the last
        logic [DATA_W-1:0]  rdata;      // Read answer
        logic               rvalid;     // Read answer strobe
        logic [DATA_W-1:0]  q_data;     // Packed bytes to the queue
        logic [2:0]         q_count;    // Bytes valid in q_data
        logic               q_valid;    // Queue push strobe
    } state_s;

endpackage

`default_nettype wire

/* File: tx_queue_write_setup.sv */
// Purpose: Transmit write setup for one buffer queue: size, masks, counter
// Assumes: One host access per cycle, inputs synchronous to i_clock
// Notes:   Each data write yields one packed push of 0 to 4 bytes
`default_nettype none

// Functional notes
// - 16-bit packet byte size, read/write, resets zero
// - Byte order bit picks high or low first
// - Start mask drops leading bytes while counter non-zero
// - Start mask clears itself once applied
// - End mask drops trailing bytes when counter zero
// - End mask persists until host clears it
// - Remaining size below four overrides end mask
// - 14-bit counter decrements per data write, stops zero
module tx_queue_write_setup
    import tx_queue_pkg::*;
(
    input  wire logic                            i_clock,     // 50 MHz clock
    input  wire logic                            i_rst_n,     // Async reset, active low
    input  wire logic [tx_queue_pkg::ADDR_W-1:0] i_addr,      // Register byte address
    input  wire logic                            i_wr_en,     // Write strobe
    input  wire logic                            i_rd_en,     // Read strobe
    input  wire logic [tx_queue_pkg::DATA_W-1:0] i_wdata,     // Write data
    output var  logic [tx_queue_pkg::DATA_W-1:0] o_rdata,     // Read data
    output var  logic                            o_rvalid,    // Read data strobe
    output var  logic [tx_queue_pkg::DATA_W-1:0] o_q_data,    // Bytes to queue, slot 0 low
    output var  logic [2:0]                      o_q_count,   // Bytes valid
    output var  logic                            o_q_valid    // Queue push strobe
);
    import tx_queue_pkg::*;

    // ****************************************
    // Reset release
    // ****************************************
    logic [1:0] rst_pipe_reg;                     // Release synchroniser
    logic       rst_n;                            // Synchronised reset

    // Assert at once, release after two edges to avoid metastable release
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_pipe_reg <= 2'h0;
        end else begin
            rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_pipe_reg[1];

    // ****************************************
    // State and decode
    // ****************************************
    state_s st_reg;                               // Registered state
    state_s st_next;                              // Next state
    logic   data_wr;                              // Data word written
    logic   count_nz;                             // Counter above zero
    logic [MASK_W-1:0] start_eff;                 // Start mask in force
    logic [MASK_W-1:0] end_eff;                   // End mask in force
    logic [2:0] avail;                            // Bytes after start trim
    logic [2:0] trimmed;                          // Bytes after both masks
    logic [2:0] limit;                            // Bytes allowed at tail
    logic [2:0] keep;                             // Bytes stored
    logic [DATA_W-1:0] packed_word;               // Trimmed bytes in send order

    assign data_wr  = i_wr_en && (i_addr == OFF_QUEUE_DATA);
    assign count_nz = (st_reg.count != COUNT_RESET);

    // ****************************************
    // Byte trimming
    // ****************************************
    always_comb begin
        start_eff = count_nz ? st_reg.start_off : MASK_RESET;
        end_eff   = count_nz ? MASK_RESET : st_reg.end_off;
        avail     = WORD_BYTES - {1'b0, start_eff};
        // Only one mask is in force at a time, so the sum stays under a word and the clamp is never taken
        trimmed   = ({1'b0, start_eff} + {1'b0, end_eff} > WORD_BYTES) ? 3'h0
                    : 3'(WORD_BYTES - {1'b0, start_eff} - {1'b0, end_eff});
        // Short remainder beats the end mask
        limit     = (st_reg.psz < SIZE_W'(WORD_BYTES)) ? st_reg.psz[2:0] : trimmed;
        keep      = (limit < avail) ? limit : avail;
    end

    // One picker per byte slot
    for (genvar g = 0; g < LANES; g++) begin : g_slot
        byte_slot #(
            .SLOT     (g)
        ) u_slot (
            .i_word   (i_wdata),
            .i_endian (st_reg.endian),
            .i_first  (start_eff),
            .i_keep   (keep),
            .o_byte   (packed_word[8*g +: 8])
        );
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        st_next         = st_reg;
        st_next.q_valid = 1'b0;
        st_next.rvalid  = 1'b0;
        // Register reads; unmapped offsets read zero
        if (i_rd_en) begin
            st_next.rvalid = 1'b1;
            st_next.rdata  = WORD_ZERO;
            if (i_addr == OFF_PACKET_BYTE_SIZE) begin
                st_next.rdata[SIZE_LSB +: SIZE_W] = st_reg.psz;
            end else if (i_addr == OFF_TX_WRITE_SETUP) begin
                st_next.rdata[ENDIAN_BIT]               = st_reg.endian;
                st_next.rdata[START_LSB +: MASK_W]      = st_reg.start_off;
                st_next.rdata[END_LSB +: MASK_W]        = st_reg.end_off;
                st_next.rdata[COUNT_LSB +: COUNT_W]     = st_reg.count;
            end
        end
        // Register writes
        if (i_wr_en && i_addr == OFF_PACKET_BYTE_SIZE) begin
            st_next.psz = i_wdata[SIZE_LSB +: SIZE_W];
        end
        if (i_wr_en && i_addr == OFF_TX_WRITE_SETUP) begin
            st_next.endian    = i_wdata[ENDIAN_BIT];
            st_next.start_off = i_wdata[START_LSB +: MASK_W];
            st_next.end_off   = i_wdata[END_LSB +: MASK_W];
            st_next.count     = i_wdata[COUNT_LSB +: COUNT_W];
        end
        // Data write: push trimmed bytes and step the counter
        if (data_wr) begin
            st_next.q_valid = 1'b1;
            st_next.q_data  = packed_word;
            st_next.q_count = keep;
            // Keep never exceeds the remainder, so no underflow
            st_next.psz     = st_reg.psz - SIZE_W'(keep);
            if (count_nz) begin
                st_next.count     = st_reg.count - COUNT_W'(1);
                st_next.start_off = MASK_RESET;
            end
            // End mask left alone; host must clear it
        end
    end

    // Single state register
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '{psz: SIZE_RESET, endian: 1'b0, start_off: MASK_RESET,
                        end_off: MASK_RESET, count: COUNT_RESET, rdata: WORD_ZERO,
                        rvalid: 1'b0, q_data: WORD_ZERO, q_count: 3'h0,
                        q_valid: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from the state flops
    assign o_rdata   = st_reg.rdata;
    assign o_rvalid  = st_reg.rvalid;
    assign o_q_data  = st_reg.q_data;
    assign o_q_count = st_reg.q_count;
    assign o_q_valid = st_reg.q_valid;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!rst_n);

    sequence s_mid_write;
        data_wr && count_nz;
    endsequence

    sequence s_last_write;
        data_wr && !count_nz;
    endsequence

    chk_size_load: assert property (
        i_wr_en && i_addr == OFF_PACKET_BYTE_SIZE |=> st_reg.psz == $past(i_wdata[15:0]))
        else $error("packet size not loaded");

    chk_big_first: assert property (
        data_wr && st_reg.endian && start_eff == 2'h0 && st_reg.psz >= 16'h0004
        |=> o_q_data[7:0] == $past(i_wdata[31:24]))
        else $error("big endian first byte wrong");

    chk_start_trim: assert property (
        s_mid_write ##0 (st_reg.start_off == 2'h2 && st_reg.psz >= 16'h0004)
        |=> o_q_valid && o_q_count == 3'h2)
        else $error("start mask not applied");

    chk_start_clear: assert property (
        s_mid_write |=> st_reg.start_off == 2'h0)
        else $error("start mask not cleared");

    chk_end_trim: assert property (
        s_last_write ##0 (st_reg.end_off == 2'h1 && st_reg.psz >= 16'h0004)
        |=> o_q_count == 3'h3)
        else $error("end mask not applied");

    chk_end_hold: assert property (
        s_last_write |=> st_reg.end_off == $past(st_reg.end_off))
        else $error("end mask changed by data write");

    chk_short_tail: assert property (
        s_last_write ##0 (st_reg.psz < 16'h0004)
        |=> o_q_count == $past(st_reg.psz[2:0]))
        else $error("short remainder did not override");

    chk_count_step: assert property (
        s_mid_write |=> st_reg.count == $past(st_reg.count) - 14'h0001)
        else $error("counter did not step");

    chk_count_floor: assert property (
        s_last_write |=> st_reg.count == 14'h0000)
        else $error("counter left zero");

    chk_bytes_drop: assert property (
        data_wr |=> st_reg.psz == $past(st_reg.psz) - 16'(o_q_count))
        else $error("remaining size not reduced by stored bytes");

endmodule

`default_nettype wire

/* File: tx_queue_write_setup_bench.sv */
// Purpose: Self-checking bench for the transmit write setup block
// Assumes: Host model owns the register port; bench checks ports only
// Notes:   Expected values are worked out by hand from the field layout
`default_nettype none

module tx_queue_write_setup_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import tx_queue_pkg::*;

    // ****************************************
    // Clock, reset and wiring
    // ****************************************
    logic                i_clock = 1'b0;   // 50 MHz clock
    logic                i_rst_n = 1'b0;   // Active low reset
    logic [ADDR_W-1:0]   addr;             // Host address
    logic                wr_en;            // Host write strobe
    logic                rd_en;            // Host read strobe
    logic [DATA_W-1:0]   wdata;            // Host write data
    logic [DATA_W-1:0]   rdata;            // Read answer
    logic                rvalid;           // Read answer strobe
    logic [DATA_W-1:0]   q_data;           // Pushed bytes
    logic [2:0]          q_count;          // Pushed byte count
    logic                q_valid;          // Push strobe
    int                  bad_count = 0;    // Mismatches
    int                  samples_checked = 0; // Comparisons

    // Half period of 10 ns
    always #10 i_clock = ~i_clock;

    tx_queue_write_setup u_tx_queue_write_setup (.i_clock(i_clock), .i_rst_n(i_rst_n),
        .i_addr(addr), .i_wr_en(wr_en), .i_rd_en(rd_en), .i_wdata(wdata), .o_rdata(rdata),
        .o_rvalid(rvalid), .o_q_data(q_data), .o_q_count(q_count), .o_q_valid(q_valid));

    host_model u_host_model (.i_clock(i_clock), .o_addr(addr), .o_wr_en(wr_en),
        .o_rd_en(rd_en), .o_wdata(wdata), .i_rdata(rdata), .i_rvalid(rvalid));

    // ****************************************
    // Checking helpers
    // ****************************************
    // Compare and count
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Read a register and compare its answer
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic        ok;
        u_host_model.rd(a, d, ok);
        check("rvalid", {31'h0, ok}, 32'h0000_0001);
        check("rdata", d, exp);
    endtask

    // Push one data word and compare the packed result
    task automatic push_chk(input logic [31:0] w, input logic [31:0] exp_d,
                            input logic [2:0] exp_n);
        u_host_model.wr(OFF_QUEUE_DATA, w);
        #1;
        check("q_valid", {31'h0, q_valid}, 32'h0000_0001);
        check("q_data", q_data, exp_d);
        check("q_count", {29'h0, q_count}, {29'h0, exp_n});
    endtask

    // Verdict and end of run
    task automatic close_out();
        if (bad_count == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        repeat (3) @(posedge i_clock);
        i_rst_n <= 1'b1;
        repeat (3) @(posedge i_clock);
        // Reset values and reserved bits
        rd_chk(12'h004, 32'h0000_0000);
        rd_chk(12'h008, 32'h0000_0000);
        u_host_model.wr(12'h004, 32'hFFFF_FFFF);
        rd_chk(12'h004, 32'h0000_FFFF);
        u_host_model.wr(12'h008, 32'hFFFF_FFFF);
        rd_chk(12'h008, 32'h010F_3FFF);
        // Unmapped place ignores writes and reads zero
        u_host_model.wr(12'h020, 32'h1234_5678);
        rd_chk(12'h020, 32'h0000_0000);
        // Start mask once, then size override of end mask
        u_host_model.setup_pkt(16'h0006, 1'b0, 2'h1, 2'h2, 14'h0002);
        rd_chk(12'h008, 32'h0006_0001);
        push_chk(32'h4433_2211, 32'h0044_3322, 3'h3);
        rd_chk(12'h008, 32'h0002_0000);
        rd_chk(12'h004, 32'h0000_0003);
        push_chk(32'h8877_6655, 32'h0077_6655, 3'h3);
        rd_chk(12'h004, 32'h0000_0000);
        // High byte first with a sticky end mask
        u_host_model.setup_pkt(16'h0100, 1'b1, 2'h0, 2'h1, 14'h0001);
        push_chk(32'hAABB_CCDD, 32'h00CC_BBAA, 3'h3);
        push_chk(32'h1122_3344, 32'h0033_2211, 3'h3);
        rd_chk(12'h008, 32'h0101_0000);
        rd_chk(12'h004, 32'h0000_00FA);
        // Counter steps down, start mask only on the first word
        u_host_model.setup_pkt(16'h0100, 1'b0, 2'h3, 2'h0, 14'h0003);
        push_chk(32'h1122_3344, 32'h0000_0011, 3'h1);
        rd_chk(12'h008, 32'h0000_0001);
        push_chk(32'h5566_7788, 32'h5566_7788, 3'h4);
        push_chk(32'h99AA_BBCC, 32'h99AA_BBCC, 3'h4);
        rd_chk(12'h008, 32'h0000_0000);
        // Two-byte start trim high first, then a short tail
        u_host_model.setup_pkt(16'h0008, 1'b1, 2'h2, 2'h0, 14'h0002);
        push_chk(32'h1122_3344, 32'h0000_4433, 3'h2);
        push_chk(32'h5566_7788, 32'h8877_6655, 3'h4);
        push_chk(32'hAABB_CCDD, 32'h0000_BBAA, 3'h2);
        rd_chk(12'h004, 32'h0000_0000);
        close_out();
    end

    // Watchdog well past the expected run length
    initial begin
        repeat (3000) @(posedge i_clock);
        bad_count++;
        close_out();
    end

endmodule

`default_nettype wire
